//--- rtl/dtw_timer_wdog.sv
// Two 16-bit down-counting timers, a timer 1 capture register and a
// watchdog with an unlock sequence, behind the byte-wide peripheral bus.
// Assumes the four capture sources are raw status levels from logic on
// ref_clk_i, and that wdt_nrst_o is fed back into the system reset.
`timescale 1ns/10ps
`include "dtw_defines.svh"

module dtw_timer_wdog
   import dtw_pkg::*;
#(
   parameter int unsigned WD_CYC0 = `DTW_WD_TIME0_MS * `DTW_CLK_MHZ * 1000,
   parameter int unsigned WD_CYC1 = `DTW_WD_TIME1_MS * `DTW_CLK_MHZ * 1000,
   parameter int unsigned WD_CYC2 = `DTW_WD_TIME2_MS * `DTW_CLK_MHZ * 1000,
   parameter int unsigned WD_CYC3 = `DTW_WD_TIME3_MS * `DTW_CLK_MHZ * 1000
) (
   // Clock, reset, enable
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        clk_en_i,
   // Peripheral bus
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [7:0]  pwdata_i,
   output logic      [7:0]  prdata_o,
   // Capture sources, raw status levels
   input  wire logic        ind_change_i,
   input  wire logic        ext_irq_i,
   input  wire logic        port2_change_i,
   input  wire logic        port1_change_i,
   // Timer and watchdog outputs
   output logic      [1:0]  tmr_irq_o,
   output logic      [1:0]  tmr_toggle_o,
   output logic             wdt_nrst_o
);

   // ***************************************************************
   // Constants and helpers
   // ***************************************************************
   localparam int unsigned WDW = 28;
   localparam logic [WDW-1:0] WD_PULSE = WDW'(`DTW_WD_PULSE_CYC);

   // Watchdog reload count for a period selection
   function automatic logic [WDW-1:0] wd_reload(input logic [1:0] sel);
      logic [WDW-1:0] r;
      r = WDW'(WD_CYC3);
      unique case (sel)
         2'h0: r = WDW'(WD_CYC0);
         2'h1: r = WDW'(WD_CYC1);
         2'h2: r = WDW'(WD_CYC2);
         2'h3: r = WDW'(WD_CYC3);
      endcase
      return r;
   endfunction : wd_reload

   // Status code of a watchdog state
   function automatic logic [1:0] wd_code(input dtw_wd_state_t s);
      logic [1:0] c;
      c = 2'h3;
      unique case (s)
         DTW_WD_COUNT:   c = 2'h0;
         DTW_WD_UNLOCK1: c = 2'h1;
         DTW_WD_UNLOCK2: c = 2'h2;
         DTW_WD_OFF:     c = 2'h3;
      endcase
      return c;
   endfunction : wd_code

   // ***************************************************************
   // Bus decode
   // ***************************************************************
   logic wr_en;
   logic rd_setup;
   assign wr_en    = clk_en_i & psel_i & penable_i & pwrite_i;
   assign rd_setup = clk_en_i & psel_i & ~penable_i & ~pwrite_i;

   function automatic logic wr_at(input logic [11:0] a);
      return wr_en && (paddr_i == a);
   endfunction : wr_at

   // ***************************************************************
   // State
   // ***************************************************************
   dtw_cmd_t       cmd;
   logic [15:0]    cnt [2];
   logic [15:0]    rld [2];
   logic [15:0]    cap;
   logic [1:0]     csel;
   logic [1:0]     wd_sel;
   dtw_wd_state_t  wd_state;
   logic [WDW-1:0] wd_cnt;
   logic [WDW-1:0] pulse_cnt;
   logic [3:0]     pre;
   logic [3:0]     src_q;
   logic           cap_evt;
   logic [1:0]     tick;
   logic [1:0]     init_req;
   logic [1:0]     run;

   // Prescaler: fast tick every 4 clocks, slow every 16
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pre <= 4'h0;
      end else if (clk_en_i) begin
         pre <= pre + 4'h1;
      end
   end

   logic fast_tick;
   logic slow_tick;
   assign fast_tick = (pre[1:0] == 2'(`DTW_FAST_DIV - 1));
   assign slow_tick = (pre == 4'(`DTW_SLOW_DIV - 1));
   assign tick[0]  = cmd.t1_fast ? fast_tick : slow_tick;
   assign tick[1]  = cmd.t2_fast ? fast_tick : slow_tick;
   assign run      = {cmd.t2_count, cmd.t1_count};
   assign init_req = {cmd.t2_init, cmd.t1_init};

   // ***************************************************************
   // Timer command register
   // ***************************************************************
   // Init bits stand for one cycle only, so they read back as zero
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cmd <= dtw_cmd_t'(`DTW_CMD_RESET);
      end else if (clk_en_i) begin
         cmd.t1_init <= 1'b0;
         cmd.t2_init <= 1'b0;
         if (wr_at(`DTW_ADDR_CMD)) begin
            cmd.t1_count <= pwdata_i[0];
            cmd.t1_init  <= pwdata_i[1];
            cmd.t1_fast  <= pwdata_i[2];
            cmd.t2_count <= pwdata_i[4];
            cmd.t2_init  <= pwdata_i[5];
            cmd.t2_fast  <= pwdata_i[6];
         end
         // Arming write wins over a capture in the same cycle
         if (wr_at(`DTW_ADDR_CMD)) begin
            cmd.cap_arm <= pwdata_i[3];
         end else if (cap_evt) begin
            cmd.cap_arm <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Reload values and counters
   // ***************************************************************
   // Byte writes go to the reload value only, never the live count
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rld[0] <= `DTW_CNT_RESET;
         rld[1] <= `DTW_CNT_RESET;
      end else if (clk_en_i) begin
         if (wr_at(`DTW_ADDR_T1_LOW))  rld[0][7:0]  <= pwdata_i;
         if (wr_at(`DTW_ADDR_T1_HIGH)) rld[0][15:8] <= pwdata_i;
         if (wr_at(`DTW_ADDR_T2_LOW))  rld[1][7:0]  <= pwdata_i;
         if (wr_at(`DTW_ADDR_T2_HIGH)) rld[1][15:8] <= pwdata_i;
      end
   end

   // Counters: init first, then timeout reload, then decrement
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt[0]       <= `DTW_CNT_RESET;
         cnt[1]       <= `DTW_CNT_RESET;
         tmr_irq_o    <= 2'h0;
         tmr_toggle_o <= 2'h0;
      end else if (clk_en_i) begin
         for (int i = 0; i < 2; i++) begin
            tmr_irq_o[i] <= 1'b0;
            if (init_req[i]) begin
               cnt[i] <= rld[i];
            end else if (run[i] && tick[i]) begin
               if (cnt[i] == 16'h0000) begin
                  cnt[i]          <= rld[i];
                  tmr_irq_o[i]    <= 1'b1;
                  tmr_toggle_o[i] <= ~tmr_toggle_o[i];
               end else begin
                  cnt[i] <= cnt[i] - 16'h0001;
               end
            end
         end
      end
   end

   // ***************************************************************
   // Timer 1 capture
   // ***************************************************************
   logic [3:0] src;
   logic [3:0] src_rise;
   assign src      = {port1_change_i, port2_change_i, ext_irq_i,
                      ind_change_i};
   assign src_rise = src & ~src_q;

   // Source history for edge detection, same clock so no synchroniser
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         src_q <= 4'h0;
      end else if (clk_en_i) begin
         src_q <= src;
      end
   end

   always_comb begin
      cap_evt = 1'b0;
      unique case (csel)
         `DTW_SRC_IND:   cap_evt = src_rise[0];
         `DTW_SRC_EXT:   cap_evt = src_rise[1];
         `DTW_SRC_PORT2: cap_evt = src_rise[2];
         `DTW_SRC_PORT1: cap_evt = src_rise[3];
      endcase
      cap_evt = cap_evt & cmd.cap_arm;
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cap  <= `DTW_CAP_RESET;
         csel <= `DTW_CSEL_RESET;
      end else if (clk_en_i) begin
         if (cap_evt) begin
            cap <= cnt[0];
         end
         if (wr_at(`DTW_ADDR_CSEL)) begin
            csel <= pwdata_i[1:0];
         end
      end
   end

   // ***************************************************************
   // Watchdog
   // ***************************************************************
   logic       wd_wr;
   logic [7:0] wd_word;
   logic       wd_kick;
   // Written out: a continuous assign of wr_at would not follow wr_en
   assign wd_wr   = wr_en && (paddr_i == `DTW_ADDR_WD_CMD);
   assign wd_word = pwdata_i;

   // Unlock sequence; any command write while off turns it back on
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wd_state <= DTW_WD_OFF;
      end else if (clk_en_i && wd_wr) begin
         unique case (wd_state)
            DTW_WD_OFF:
               wd_state <= DTW_WD_COUNT;
            DTW_WD_COUNT:
               if (wd_word == `DTW_UNLOCK_ONE) begin
                  wd_state <= DTW_WD_UNLOCK1;
               end
            DTW_WD_UNLOCK1:
               if (wd_word == `DTW_UNLOCK_TWO) begin
                  wd_state <= DTW_WD_UNLOCK2;
               end else if (wd_word == `DTW_UNLOCK_ONE) begin
                  wd_state <= DTW_WD_UNLOCK1;
               end else begin
                  wd_state <= DTW_WD_COUNT;
               end
            DTW_WD_UNLOCK2:
               if (wd_word == `DTW_UNLOCK_THREE) begin
                  wd_state <= DTW_WD_OFF;
               end else if (wd_word == `DTW_UNLOCK_ONE) begin
                  wd_state <= DTW_WD_UNLOCK1;
               end else begin
                  wd_state <= DTW_WD_COUNT;
               end
         endcase
      end
   end

   // Kick reloads; enabling from off also starts a fresh period
   assign wd_kick = wd_wr &&
                    ((wd_word == `DTW_KICK_WORD) || wd_state == DTW_WD_OFF);

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wd_sel <= `DTW_WDSEL_RESET;
      end else if (clk_en_i && wr_at(`DTW_ADDR_WATCHDOG_STATUS_CONTROL)) begin
         wd_sel <= pwdata_i[1:0];
      end
   end

   // Counter runs in every state except off; zero starts the pulse
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wd_cnt    <= WDW'(WD_CYC3);
         pulse_cnt <= '0;
         wdt_nrst_o <= 1'b1;
      end else if (clk_en_i) begin
         if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - 1'b1;
         end
         wdt_nrst_o <= (pulse_cnt == '0) || (pulse_cnt == WDW'(1));
         if (wd_kick) begin
            wd_cnt <= wd_reload(wd_sel);
         end else if (wd_state != DTW_WD_OFF) begin
            if (wd_cnt == '0) begin
               // Reload so a missing system reset gives periodic pulses
               wd_cnt    <= wd_reload(wd_sel);
               pulse_cnt <= WD_PULSE;
               wdt_nrst_o <= 1'b0;
            end else begin
               wd_cnt <= wd_cnt - 1'b1;
            end
         end
      end
   end

   // ***************************************************************
   // Read data, sampled in the setup phase
   // ***************************************************************
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prdata_o <= 8'h00;
      end else if (rd_setup) begin
         unique case (paddr_i)
            `DTW_ADDR_T1_LOW:   prdata_o <= cnt[0][7:0];
            `DTW_ADDR_T1_HIGH:  prdata_o <= cnt[0][15:8];
            `DTW_ADDR_T2_LOW:   prdata_o <= cnt[1][7:0];
            `DTW_ADDR_T2_HIGH:  prdata_o <= cnt[1][15:8];
            `DTW_ADDR_CMD:      prdata_o <= cmd;
            `DTW_ADDR_CAP_LOW:  prdata_o <= cap[7:0];
            `DTW_ADDR_CAP_HIGH: prdata_o <= cap[15:8];
            `DTW_ADDR_CSEL:     prdata_o <= {6'h00, csel};
            `DTW_ADDR_WATCHDOG_STATUS_CONTROL:
               prdata_o <= {4'h0, wd_code(wd_state), wd_sel};
            default:            prdata_o <= 8'h00;
         endcase
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking dcb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_unlock_two;
      clk_en_i && wd_wr && wd_word == `DTW_UNLOCK_TWO
         && wd_state == DTW_WD_UNLOCK1;
   endsequence

   sequence s_unlock_three;
      clk_en_i && wd_wr && wd_word == `DTW_UNLOCK_THREE
         && wd_state == DTW_WD_UNLOCK2;
   endsequence

   a_init_self_clear: assert property (
      clk_en_i && wr_at(`DTW_ADDR_CMD) && pwdata_i[1]
      |=> cmd.t1_init ##1 !cmd.t1_init && cnt[0] == $past(rld[0]))
      else $error("timer 1 init did not reload or self-clear");

   a_hold_when_idle: assert property (
      !run[0] && !init_req[0] |=> cnt[0] == $past(cnt[0]))
      else $error("timer 1 moved while not counting");

   a_timeout_event: assert property (
      clk_en_i && run[0] && tick[0] && !init_req[0] && cnt[0] == 16'h0000
      |=> tmr_irq_o[0] && cnt[0] == $past(rld[0])
          && tmr_toggle_o[0] != $past(tmr_toggle_o[0]))
      else $error("timer 1 timeout not handled");

   a_capture_once: assert property (
      cap_evt && !wr_at(`DTW_ADDR_CMD)
      |=> !cmd.cap_arm && cap == $past(cnt[0]))
      else $error("capture did not latch or disarm");

   a_disarmed_keeps: assert property (
      !cmd.cap_arm |=> cap == $past(cap))
      else $error("capture changed while not armed");

   a_unlock_step_two: assert property (
      s_unlock_two |=> wd_state == DTW_WD_UNLOCK2)
      else $error("second unlock word did not advance");

   // Other bus traffic may fall between the words; 32 cycles covers it
   a_unlock_full_seq: assert property (
      s_unlock_two ##[1:32] s_unlock_three
      |=> wd_state == DTW_WD_OFF)
      else $error("unlock sequence did not disable watchdog");

   a_wrong_restart: assert property (
      clk_en_i && wd_wr && wd_state == DTW_WD_UNLOCK2
      && wd_word != `DTW_UNLOCK_THREE && wd_word != `DTW_UNLOCK_ONE
      |=> wd_state == DTW_WD_COUNT)
      else $error("wrong word did not restart the sequence");

   a_enable_on_write: assert property (
      clk_en_i && wd_wr && wd_state == DTW_WD_OFF
      |=> wd_state == DTW_WD_COUNT && wd_cnt == wd_reload(wd_sel))
      else $error("write while off did not enable watchdog");

   a_kick_reload: assert property (
      clk_en_i && wd_wr && wd_word == `DTW_KICK_WORD
      |=> wd_cnt == wd_reload($past(wd_sel)))
      else $error("kick did not reload watchdog");

   a_reset_pulse: assert property (
      clk_en_i && !wd_kick && wd_state != DTW_WD_OFF && wd_cnt == '0
      |=> !wdt_nrst_o [*8])
      else $error("watchdog timeout gave no reset pulse");

   a_status_read: assert property (
      rd_setup && paddr_i == `DTW_ADDR_WATCHDOG_STATUS_CONTROL
      |=> prdata_o[3:2] == wd_code($past(wd_state))
          && prdata_o[1:0] == $past(wd_sel))
      else $error("watchdog status read wrong");

endmodule : dtw_timer_wdog

//--- shared/dtw_defines.svh
// Offsets, reset values, source codes, command words and timing counts of the
// dual timer and watchdog register block.
// Assumes byte addresses on the peripheral bus, registers one word apart.
`ifndef DTW_DEFINES_SVH
`define DTW_DEFINES_SVH

// ******************************************************************
// Register byte addresses
// ******************************************************************
`define DTW_ADDR_T1_LOW   12'h300
`define DTW_ADDR_T1_HIGH  12'h304
`define DTW_ADDR_T2_LOW   12'h308
`define DTW_ADDR_T2_HIGH  12'h30C
`define DTW_ADDR_CMD      12'h310
`define DTW_ADDR_CAP_LOW  12'h314
`define DTW_ADDR_CAP_HIGH 12'h318
`define DTW_ADDR_CSEL     12'h31C
`define DTW_ADDR_WATCHDOG_STATUS_CONTROL    12'h320
`define DTW_ADDR_WD_CMD   12'h324

// ******************************************************************
// Reset values
// ******************************************************************
`define DTW_CNT_RESET     16'hFFFF
`define DTW_CAP_RESET     16'hFFFF
`define DTW_CMD_RESET     8'h00
`define DTW_CSEL_RESET    2'h0
`define DTW_WDSEL_RESET   2'h3

// ******************************************************************
// Capture sources and watchdog command words
// ******************************************************************
`define DTW_SRC_IND       2'h0
`define DTW_SRC_EXT       2'h1
`define DTW_SRC_PORT2     2'h2
`define DTW_SRC_PORT1     2'h3
`define DTW_KICK_WORD     8'hDC
`define DTW_UNLOCK_ONE    8'hA5
`define DTW_UNLOCK_TWO    8'h5A
`define DTW_UNLOCK_THREE  8'hAF

// ******************************************************************
// Timing
// ******************************************************************
`define DTW_CLK_MHZ       200
`define DTW_FAST_DIV      4
`define DTW_SLOW_DIV      16
`define DTW_WD_TIME0_MS   480
`define DTW_WD_TIME1_MS   610
`define DTW_WD_TIME2_MS   890
`define DTW_WD_TIME3_MS   1020
`define DTW_WD_PULSE_CYC  16

`endif

//--- shared/dtw_pkg.sv
// Types shared by the dual timer and watchdog register block.
// Assumes nothing beyond a SystemVerilog compiler.
package dtw_pkg;

   // Timer command register layout, bit 7 down to bit 0
   typedef struct packed {
      logic spare;
      logic t2_fast;
      logic t2_init;
      logic t2_count;
      logic cap_arm;
      logic t1_fast;
      logic t1_init;
      logic t1_count;
   } dtw_cmd_t;

   // Watchdog state machine
   typedef enum logic [1:0] {
      DTW_WD_COUNT,
      DTW_WD_UNLOCK1,
      DTW_WD_UNLOCK2,
      DTW_WD_OFF
   } dtw_wd_state_t;

endpackage : dtw_pkg

//--- dv/dual_timer_watchdog_regs_tb.sv
// Self-checking bench for the dual timer and watchdog register block.
// Assumes dtw_defines.svh on the include path and the design compiled.
`timescale 1ns/10ps
`include "dtw_defines.svh"

module dual_timer_watchdog_regs_tb;
   logic        ref_clk_i  = 1'b0;
   logic        nrst_i     = 1'b0;
   logic        clk_en_i   = 1'b1;
   logic        psel_i     = 1'b0;
   logic        penable_i  = 1'b0;
   logic        pwrite_i   = 1'b0;
   logic [11:0] paddr_i    = 12'h000;
   logic [7:0]  pwdata_i   = 8'h00;
   logic [3:0]  src        = 4'h0;
   logic [7:0]  prdata_o;
   logic [1:0]  tmr_irq_o;
   logic [1:0]  tmr_toggle_o;
   logic        wdt_nrst_o;
   int          num_errors = 0;
   int          n_tests    = 0;
   int          wd_st      = 3;
   int          t, f, n, w, tg, low;
   logic [15:0] r, p, rl;
   logic [11:0] base;
   logic [11:0] ra [10] = '{`DTW_ADDR_T1_LOW, `DTW_ADDR_T1_HIGH,
      `DTW_ADDR_T2_LOW, `DTW_ADDR_T2_HIGH, `DTW_ADDR_CMD, `DTW_ADDR_CAP_LOW,
      `DTW_ADDR_CAP_HIGH, `DTW_ADDR_CSEL, `DTW_ADDR_WATCHDOG_STATUS_CONTROL, 12'h328};
   logic [7:0]  rv [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF,
      8'hFF, 8'h00, 8'h0F, 8'h00};
   logic [7:0]  seq [12] = '{8'h11, 8'hA5, 8'h5A, 8'hAF, 8'h22, 8'hA5,
      8'h33, 8'hA5, 8'hA5, 8'h5A, 8'h44, 8'hDC};

   // Free-running 200 MHz clock
   always #2.5 ref_clk_i = ~ref_clk_i;

   // Short watchdog periods keep the run brief
   dtw_timer_wdog #(.WD_CYC0(200), .WD_CYC1(300), .WD_CYC2(400),
      .WD_CYC3(500)) dut (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .ind_change_i(src[0]), .ext_irq_i(src[1]),
      .port2_change_i(src[2]), .port1_change_i(src[3]),
      .tmr_irq_o(tmr_irq_o), .tmr_toggle_o(tmr_toggle_o),
      .wdt_nrst_o(wdt_nrst_o));

   // ****************************************************************
   // Bus cycles, checks and the watchdog model
   // ****************************************************************
   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk_i);
   endtask : cyc

   // Setup then access; request held until the storing edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= 1'b1;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      @(posedge ref_clk_i);
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : wr

   // Read data is registered at the end of setup, taken at access end
   task automatic rchk(input string nm, input logic [11:0] a,
                       input logic [7:0] exp);
      @(posedge ref_clk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= 1'b0;
      paddr_i   <= a;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      @(posedge ref_clk_i);
      chk(nm, {8'h00, prdata_o}, {8'h00, exp});
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : rchk

   task automatic pulse(input logic [3:0] m);
      @(posedge ref_clk_i);
      src <= m;
      @(posedge ref_clk_i);
      src <= 4'h0;
      cyc(2);
   endtask : pulse

   task automatic wait_irq(input int ti, output int k);
      k = 0;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while (tmr_irq_o[ti] !== 1'b1 && k < 2000);
      if (k >= 2000) begin
         num_errors++;
         complete_run();
      end
   endtask : wait_irq

   // Unlock sequence model: kick or any word while off restarts counting
   function automatic int wd_model(input int st, input logic [7:0] v);
      if (st == 3 || v == `DTW_KICK_WORD) return 0;
      if (v == `DTW_UNLOCK_ONE) return 1;
      if (st == 1 && v == `DTW_UNLOCK_TWO) return 2;
      if (st == 2 && v == `DTW_UNLOCK_THREE) return 3;
      return 0;
   endfunction : wd_model

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      void'($urandom(77));
      repeat (6) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      // Reset values, unmapped place reads zero
      foreach (ra[i]) rchk("reset", ra[i], rv[i]);
      // Capture on every source, timer 1 held
      p = 16'hFFFF;
      for (int s = 0; s < 4; s++) begin
         r = 16'($urandom);
         wr(`DTW_ADDR_T1_LOW, r[7:0]);
         wr(`DTW_ADDR_T1_HIGH, r[15:8]);
         rchk("cnt_old", `DTW_ADDR_T1_LOW, p[7:0]);
         wr(`DTW_ADDR_CSEL, 8'(s));
         rchk("csel", `DTW_ADDR_CSEL, 8'(s));
         wr(`DTW_ADDR_CMD, 8'h0A);
         cyc(40);
         rchk("cnt_lo", `DTW_ADDR_T1_LOW, r[7:0]);
         rchk("cnt_hi", `DTW_ADDR_T1_HIGH, r[15:8]);
         pulse(4'(1) << ((s + 1) % 4));
         rchk("armed", `DTW_ADDR_CMD, 8'h08);
         pulse(4'(1) << s);
         rchk("disarm", `DTW_ADDR_CMD, 8'h00);
         wr(`DTW_ADDR_CAP_LOW, 8'h5A);
         rchk("cap_lo", `DTW_ADDR_CAP_LOW, r[7:0]);
         rchk("cap_hi", `DTW_ADDR_CAP_HIGH, r[15:8]);
         p = 16'($urandom);
         wr(`DTW_ADDR_T1_LOW, p[7:0]);
         wr(`DTW_ADDR_T1_HIGH, p[15:8]);
         wr(`DTW_ADDR_CMD, 8'h02);
         pulse(4'(1) << s);
         rchk("cap_once", `DTW_ADDR_CAP_LOW, r[7:0]);
      end
      // Timeout period, irq and toggle, both timers, both rates
      for (int k = 0; k < 4; k++) begin
         t    = k % 2;
         f    = k / 2;
         rl   = 16'($urandom_range(6, 1));
         base = (t == 0) ? `DTW_ADDR_T1_LOW : `DTW_ADDR_T2_LOW;
         wr(base, rl[7:0]);
         wr(base + 12'h004, 8'h00);
         wr(`DTW_ADDR_CMD, 8'((f ? 7 : 3) << (4 * t)));
         rchk("cmd", `DTW_ADDR_CMD, 8'((f ? 5 : 1) << (4 * t)));
         wait_irq(t, n);
         cyc(2);
         tg = tmr_toggle_o[t];
         wait_irq(t, n);
         chk("period", 16'(n + 2), 16'((rl + 1) * (f ? 4 : 16)));
         cyc(1);
         chk("irq_len", 16'(tmr_irq_o[t]), 16'h0000);
         cyc(1);
         chk("toggle", 16'(tmr_toggle_o[t]), 16'(!tg));
      end
      wr(`DTW_ADDR_CMD, 8'h00);
      // Period select while disabled; state bits ignore writes
      for (int i = 3; i >= 0; i--) begin
         wr(`DTW_ADDR_WATCHDOG_STATUS_CONTROL, 8'(i));
         rchk("wd_sel", `DTW_ADDR_WATCHDOG_STATUS_CONTROL, 8'(12 + i));
      end
      // Unlock words, broken sequences and re-enable
      foreach (seq[j]) begin
         wr(`DTW_ADDR_WD_CMD, seq[j]);
         wd_st = wd_model(wd_st, seq[j]);
         rchk("wd_state", `DTW_ADDR_WATCHDOG_STATUS_CONTROL, 8'(wd_st * 4));
      end
      // A held-low clock enable freezes the watchdog past its period
      low = 0;
      clk_en_i <= 1'b0;
      repeat (300) begin
         @(posedge ref_clk_i);
         if (wdt_nrst_o !== 1'b1) low++;
      end
      clk_en_i <= 1'b1;
      // Regular kicks keep the reset line high
      repeat (4) begin
         repeat (150) begin
            @(posedge ref_clk_i);
            if (wdt_nrst_o !== 1'b1) low++;
         end
         wr(`DTW_ADDR_WD_CMD, `DTW_KICK_WORD);
      end
      chk("kick_low", 16'(low), 16'h0000);
      // Without kicks the reset pulse comes after one period
      n = 0;
      while (wdt_nrst_o === 1'b1 && n < 1000) begin
         @(posedge ref_clk_i);
         n++;
      end
      chk("wd_due", 16'(n >= 196 && n <= 212), 16'h0001);
      if (n >= 1000) complete_run();
      w = 0;
      while (wdt_nrst_o === 1'b0 && w < 100) begin
         @(posedge ref_clk_i);
         w++;
      end
      chk("wd_width", 16'(w), 16'(`DTW_WD_PULSE_CYC));
      complete_run();
   end
endmodule : dual_timer_watchdog_regs_tb
